// file: sbpl_pkg.sv
// Shared constants for the serial boot program loader and its host end
package sbpl_pkg;
    // Frame format: start, eight data bits, stop, no parity
    localparam int FRAME_BITS = 10;
    localparam int DATA_BITS = 8;
    localparam int STOP_BIT_IDX = 9;
    // Serial clock runs at sixteen times the bit rate
    localparam int OVERSAMPLE = 16;
    localparam int OVS_W = 4;
    localparam logic [OVS_W-1:0] OVS_LAST = 4'h000F;
    localparam logic [OVS_W-1:0] SAMPLE_AT = 4'h0007;
    localparam logic [3:0] BIT_STOP = 4'h0009;
    // Boot-time port settings
    localparam logic [23:0] PORT_CONTROL_BOOT = 24'h00_0302;
    localparam logic [23:0] CLOCK_CONTROL_BOOT = 24'h00_C000;
    localparam int RX_ENABLE_BIT = 8;
    localparam int TX_ENABLE_BIT = 9;
    localparam int RX_CLK_SRC_BIT = 14;
    localparam int TX_CLK_SRC_BIT = 15;
    // Mode straps as {d, c, b, a}; 0,1,0,1 selects serial boot
    localparam logic [3:0] SERIAL_BOOT_MODE = 4'h5;
    localparam logic [23:0] BOOT_ENTRY = 24'hFF_0000;
    localparam int BOOT_ROM_WORDS = 192;
    localparam logic [1:0] LAST_BYTE = 2'h2;
    localparam logic [1:0] SYNC_WAIT = 2'h3;
    // Word count that loads the second-stage loader
    localparam logic [23:0] LOADER_WORDS = 24'h00_00A0;
    // Host APB register offsets and fields
    localparam logic [11:0] HOST_CTRL_OFS = 12'h000;
    localparam logic [11:0] HOST_STATUS_OFS = 12'h004;
    localparam logic [11:0] HOST_TXDATA_OFS = 12'h008;
    localparam logic [11:0] HOST_RXDATA_OFS = 12'h00C;
    localparam int CTRL_HOLD_RESET_BIT = 0;
    localparam int CTRL_CLK_EN_BIT = 1;
    localparam logic [1:0] HOST_CTRL_RESET = 2'h3;
    localparam int ST_TX_BUSY_BIT = 0;
    localparam int ST_RX_VALID_BIT = 1;
    localparam int ST_RX_FERR_BIT = 2;

    typedef enum logic [3:0] {
        ST_LATCH = 4'b0001,
        ST_LOAD = 4'b0010,
        ST_RUN = 4'b0100,
        ST_OTHER = 4'b1000
    } sbpl_state_t;
endpackage

// file: sbpl_link_if.sv
// Serial boot link between host and device
`timescale 1ns/10ps
interface sbpl_link_if;
    logic sclk;
    logic boot_rst_n;
    logic rxd;
    logic txd;

    modport dev (
        input sclk,
        input boot_rst_n,
        input rxd,
        output txd
    );

    modport host (
        output sclk,
        output boot_rst_n,
        output rxd,
        input txd
    );
endinterface

// file: sbpl_device.sv
// Device end: serial bootstrap receiver, echo transmitter and program loader
//
// Behaviour
// - Frame: start, eight data bits, one stop.
// - Data bits travel least significant first.
// - Port control holds 0x000302 during boot.
// - Clock control 0x00C000 selects external serial clock.
// - Host clocks link at sixteen times bitrate.
// - Serial clock is input; data lines cross.
// - Host asserts then releases device reset.
// - Latch mode pins at reset release.
// - Pins 1,0,1,0 boot serially from 0xFF0000.
// - Boot ROM routine starts after every reset.
// - Words arrive low, middle, high byte.
// - Count, start address, then counted consecutive words.
// - Every received byte is echoed back.
// - After last word, execute at start address.
// - Loader: count 0xA0, address, 160 words.
// - Host keeps loader clear of application memory.
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/10ps
module sbpl_device
    import sbpl_pkg::*;
(
    // Link, clocked and reset by the host
    sbpl_link_if.dev link,
    // Boot mode straps
    input wire logic boot_select_pin_a,
    input wire logic boot_select_pin_b,
    input wire logic boot_select_pin_c,
    input wire logic boot_select_pin_d,
    // Latched mode and port settings
    output logic latched_select_bit_a,
    output logic latched_select_bit_b,
    output logic latched_select_bit_c,
    output logic latched_select_bit_d,
    output logic [23:0] serial_port_control,
    output logic [23:0] serial_port_clock_control,
    // Program memory write port
    output logic pmem_we,
    output logic [23:0] pmem_addr,
    output logic [23:0] pmem_data,
    // Execution control
    output logic boot_active,
    output logic exec_go,
    output logic [23:0] fetch_addr
);
    // The whole device runs on the host's 16x serial clock; the data pin is
    // still asynchronous to it through board delays, so it is synchronised.
    wire logic clk = link.sclk;
    wire logic rst_n = link.boot_rst_n;

    sbpl_state_t state_q;
    logic [3:0] mode_s1_q, mode_s2_q, mode_s3_q;
    logic [1:0] settle_q;
    logic [3:0] mode_q;
    logic [23:0] port_ctl_q, clk_ctl_q;
    logic rx_s1_q, rx_s2_q, rx_s3_q, rx_lvl_q, rx_prev_q;
    logic rx_on_q;
    logic [OVS_W-1:0] rx_cnt_q;
    logic [3:0] rx_bit_q;
    logic [7:0] rx_sh_q;
    logic byte_vld_q;
    logic [7:0] byte_q;
    logic tx_on_q, txd_q, pend_q;
    logic [OVS_W-1:0] tx_cnt_q;
    logic [3:0] tx_bit_q;
    logic [9:0] tx_sh_q;
    logic [7:0] pend_data_q;
    logic [1:0] byte_idx_q;
    logic [1:0] phase_q;
    logic [23:0] word_q, remain_q, start_q, waddr_q;
    logic pmem_we_q, exec_go_q;
    logic [23:0] pmem_addr_q, pmem_data_q, fetch_q;
    logic rx_en, tx_en;
    logic [23:0] full_word;

    assign rx_en = port_ctl_q[RX_ENABLE_BIT] & clk_ctl_q[RX_CLK_SRC_BIT];
    assign tx_en = port_ctl_q[TX_ENABLE_BIT] & clk_ctl_q[TX_CLK_SRC_BIT];
    assign full_word = {byte_q, word_q[23:8]};

    // Port settings are fixed at their boot values while the ROM runs
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_ctl_q <= PORT_CONTROL_BOOT;
            clk_ctl_q <= CLOCK_CONTROL_BOOT;
        end
    end

    // Strap capture: three-stage synchroniser, latched once settled
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_s1_q <= '0;
            mode_s2_q <= '0;
            mode_s3_q <= '0;
            settle_q <= '0;
        end
        else
        begin
            mode_s1_q <= {boot_select_pin_d, boot_select_pin_c,
                          boot_select_pin_b, boot_select_pin_a};
            mode_s2_q <= mode_s1_q;
            mode_s3_q <= mode_s2_q;
            if (settle_q != SYNC_WAIT)
                settle_q <= settle_q + 2'h1;
        end
    end

    // Boot sequencer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ST_LATCH;
            mode_q <= '0;
            fetch_q <= '0;
            byte_idx_q <= '0;
            phase_q <= '0;
            word_q <= '0;
            remain_q <= '0;
            start_q <= '0;
            waddr_q <= '0;
            pmem_we_q <= 1'b0;
            pmem_addr_q <= '0;
            pmem_data_q <= '0;
            exec_go_q <= 1'b0;
        end
        else
        begin
            pmem_we_q <= 1'b0;
            exec_go_q <= 1'b0;
            unique case (state_q)
                ST_LATCH:
                begin
                    if (settle_q == SYNC_WAIT && mode_s2_q == mode_s3_q)
                    begin
                        mode_q <= mode_s3_q;
                        if (mode_s3_q == SERIAL_BOOT_MODE)
                        begin
                            fetch_q <= BOOT_ENTRY;
                            state_q <= ST_LOAD;
                        end
                        else
                            state_q <= ST_OTHER;
                    end
                end
                ST_LOAD:
                begin
                    if (byte_vld_q)
                    begin
                        word_q <= full_word;
                        if (byte_idx_q != LAST_BYTE)
                            byte_idx_q <= byte_idx_q + 2'h1;
                        else
                        begin
                            byte_idx_q <= '0;
                            if (phase_q == 2'h0)
                            begin
                                remain_q <= full_word;
                                phase_q <= 2'h1;
                            end
                            else if (phase_q == 2'h1)
                            begin
                                start_q <= full_word;
                                waddr_q <= full_word;
                                phase_q <= 2'h2;
                                if (remain_q == '0)
                                begin
                                    exec_go_q <= 1'b1;
                                    fetch_q <= full_word;
                                    state_q <= ST_RUN;
                                end
                            end
                            else
                            begin
                                pmem_we_q <= 1'b1;
                                pmem_addr_q <= waddr_q;
                                pmem_data_q <= full_word;
                                waddr_q <= waddr_q + 24'h00_0001;
                                remain_q <= remain_q - 24'h00_0001;
                                if (remain_q == 24'h00_0001)
                                begin
                                    exec_go_q <= 1'b1;
                                    fetch_q <= start_q;
                                    state_q <= ST_RUN;
                                end
                            end
                        end
                    end
                end
                ST_RUN:
                    state_q <= ST_RUN;
                ST_OTHER:
                    state_q <= ST_OTHER;
            endcase
        end
    end

    // Receive line: three flops, level moves once the last two agree
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_s3_q <= 1'b1;
            rx_lvl_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end
        else
        begin
            rx_s1_q <= link.rxd;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q;
            if (rx_s2_q == rx_s3_q)
                rx_lvl_q <= rx_s3_q;
            rx_prev_q <= rx_lvl_q;
        end
    end

    // Receiver: one sclk is one sub-clock of a bit period
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_on_q <= 1'b0;
            rx_cnt_q <= '0;
            rx_bit_q <= '0;
            rx_sh_q <= '0;
            byte_vld_q <= 1'b0;
            byte_q <= '0;
        end
        else
        begin
            byte_vld_q <= 1'b0;
            if (!rx_on_q)
            begin
                if (rx_en && state_q == ST_LOAD && rx_prev_q && !rx_lvl_q)
                begin
                    rx_on_q <= 1'b1;
                    rx_cnt_q <= '0;
                    rx_bit_q <= '0;
                end
            end
            else
            begin
                rx_cnt_q <= (rx_cnt_q == OVS_LAST) ? '0 : rx_cnt_q + 1'b1;
                if (rx_cnt_q == SAMPLE_AT)
                begin
                    rx_bit_q <= rx_bit_q + 4'h1;
                    if (rx_bit_q == '0)
                    begin
                        // A start bit gone high by mid-bit was a glitch
                        if (rx_lvl_q)
                            rx_on_q <= 1'b0;
                    end
                    else if (rx_bit_q == BIT_STOP)
                    begin
                        rx_on_q <= 1'b0;
                        if (rx_lvl_q)
                        begin
                            byte_vld_q <= 1'b1;
                            byte_q <= rx_sh_q;
                        end
                    end
                    else
                        rx_sh_q <= {rx_lvl_q, rx_sh_q[7:1]};
                end
            end
        end
    end

    // Echo transmitter with a one-byte holding slot
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_on_q <= 1'b0;
            txd_q <= 1'b1;
            tx_cnt_q <= '0;
            tx_bit_q <= '0;
            tx_sh_q <= '1;
            pend_q <= 1'b0;
            pend_data_q <= '0;
        end
        else
        begin
            if (byte_vld_q && tx_en)
            begin
                pend_q <= 1'b1;
                pend_data_q <= byte_q;
            end
            else if (pend_q && !tx_on_q)
                pend_q <= 1'b0;
            if (!tx_on_q)
            begin
                if (pend_q)
                begin
                    tx_on_q <= 1'b1;
                    tx_sh_q <= {1'b1, pend_data_q, 1'b0};
                    txd_q <= 1'b0;
                    tx_cnt_q <= '0;
                    tx_bit_q <= '0;
                end
            end
            else
            begin
                tx_cnt_q <= (tx_cnt_q == OVS_LAST) ? '0 : tx_cnt_q + 1'b1;
                if (tx_cnt_q == OVS_LAST)
                begin
                    tx_bit_q <= tx_bit_q + 4'h1;
                    tx_sh_q <= {1'b1, tx_sh_q[9:1]};
                    txd_q <= tx_sh_q[1];
                    if (tx_bit_q == BIT_STOP)
                    begin
                        tx_on_q <= 1'b0;
                        txd_q <= 1'b1;
                    end
                end
            end
        end
    end

    assign link.txd = txd_q;
    assign latched_select_bit_a = mode_q[0];
    assign latched_select_bit_b = mode_q[1];
    assign latched_select_bit_c = mode_q[2];
    assign latched_select_bit_d = mode_q[3];
    assign serial_port_control = port_ctl_q;
    assign serial_port_clock_control = clk_ctl_q;
    assign pmem_we = pmem_we_q;
    assign pmem_addr = pmem_addr_q;
    assign pmem_data = pmem_data_q;
    assign exec_go = exec_go_q;
    assign fetch_addr = fetch_q;
    assign boot_active = state_q[1];
endmodule

// file: sbpl_host.sv
// Host end: APB-controlled reset, serial clock divider and byte link
`timescale 1ns/10ps
module sbpl_host
    import sbpl_pkg::*;
#(
    parameter int SCLK_HALF = 2
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link to the device
    sbpl_link_if.host link
);
    if (SCLK_HALF < 1)
    begin : g_chk
        $error("SCLK_HALF must be at least 1");
    end

    localparam int DIV_W = (SCLK_HALF < 2) ? 1 : $clog2(SCLK_HALF);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCLK_HALF - 1);

    logic [1:0] ctrl_q;
    logic [DIV_W-1:0] div_q;
    logic sclk_q, tick_q;
    logic tx_on_q, txd_q;
    logic [OVS_W-1:0] tx_cnt_q, rx_cnt_q;
    logic [3:0] tx_bit_q, rx_bit_q;
    logic [9:0] tx_sh_q;
    logic rx_s1_q, rx_s2_q, rx_s3_q, rx_lvl_q, rx_prev_q, rx_on_q;
    logic [7:0] rx_sh_q, rx_data_q;
    logic rx_vld_q, rx_ferr_q, rx_done;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic dev_rst_n_q;
    logic acc, wr_tx, rd_rx;

    assign acc = psel & penable;
    assign wr_tx = acc & pwrite & (paddr == HOST_TXDATA_OFS) & !tx_on_q;
    assign rd_rx = acc & !pwrite & (paddr == HOST_RXDATA_OFS);

    // Control register: hold the device in reset, run the serial clock
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            ctrl_q <= HOST_CTRL_RESET;
        else if (acc && pwrite && paddr == HOST_CTRL_OFS)
            ctrl_q <= pwdata[1:0];
    end

    // Device reset pin straight from a flop, so no decode glitch reaches it
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            dev_rst_n_q <= 1'b0;
        else
            dev_rst_n_q <= !ctrl_q[CTRL_HOLD_RESET_BIT];
    end

    // Serial clock divider; tick marks each rising edge made
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            div_q <= '0;
            sclk_q <= 1'b0;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= 1'b0;
            if (!ctrl_q[CTRL_CLK_EN_BIT])
                div_q <= '0;
            else if (div_q == DIV_LAST)
            begin
                div_q <= '0;
                sclk_q <= !sclk_q;
                tick_q <= !sclk_q;
            end
            else
                div_q <= div_q + 1'b1;
        end
    end

    // Transmitter: one bit lasts sixteen serial clock periods
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_on_q <= 1'b0;
            txd_q <= 1'b1;
            tx_cnt_q <= '0;
            tx_bit_q <= '0;
            tx_sh_q <= '1;
        end
        else if (wr_tx)
        begin
            tx_on_q <= 1'b1;
            tx_sh_q <= {1'b1, pwdata[7:0], 1'b0};
            txd_q <= 1'b0;
            tx_cnt_q <= '0;
            tx_bit_q <= '0;
        end
        else if (tx_on_q && tick_q)
        begin
            tx_cnt_q <= (tx_cnt_q == OVS_LAST) ? '0 : tx_cnt_q + 1'b1;
            if (tx_cnt_q == OVS_LAST)
            begin
                tx_bit_q <= tx_bit_q + 4'h1;
                tx_sh_q <= {1'b1, tx_sh_q[9:1]};
                txd_q <= tx_sh_q[1];
                if (tx_bit_q == BIT_STOP)
                begin
                    tx_on_q <= 1'b0;
                    txd_q <= 1'b1;
                end
            end
        end
    end

    // Echo receiver, sampled on the serial clock ticks
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_s3_q <= 1'b1;
            rx_lvl_q <= 1'b1;
        end
        else
        begin
            rx_s1_q <= link.txd;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q;
            if (rx_s2_q == rx_s3_q)
                rx_lvl_q <= rx_s3_q;
        end
    end

    assign rx_done = tick_q & rx_on_q & (rx_cnt_q == SAMPLE_AT) & (rx_bit_q == BIT_STOP);

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_prev_q <= 1'b1;
            rx_on_q <= 1'b0;
            rx_cnt_q <= '0;
            rx_bit_q <= '0;
            rx_sh_q <= '0;
        end
        else if (tick_q)
        begin
            rx_prev_q <= rx_lvl_q;
            if (!rx_on_q)
            begin
                if (rx_prev_q && !rx_lvl_q)
                begin
                    rx_on_q <= 1'b1;
                    rx_cnt_q <= '0;
                    rx_bit_q <= '0;
                end
            end
            else
            begin
                rx_cnt_q <= (rx_cnt_q == OVS_LAST) ? '0 : rx_cnt_q + 1'b1;
                if (rx_cnt_q == SAMPLE_AT)
                begin
                    rx_bit_q <= rx_bit_q + 4'h1;
                    if ((rx_bit_q == '0 && rx_lvl_q) || rx_bit_q == BIT_STOP)
                        rx_on_q <= 1'b0;
                    else if (rx_bit_q != '0)
                        rx_sh_q <= {rx_lvl_q, rx_sh_q[7:1]};
                end
            end
        end
    end

    // Received byte; a new byte wins over a read that clears it
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_vld_q <= 1'b0;
            rx_ferr_q <= 1'b0;
            rx_data_q <= '0;
        end
        else if (rx_done)
        begin
            rx_vld_q <= 1'b1;
            rx_ferr_q <= !rx_lvl_q;
            rx_data_q <= rx_sh_q;
        end
        else if (rd_rx)
        begin
            rx_vld_q <= 1'b0;
            rx_ferr_q <= 1'b0;
        end
    end

    // APB answer: zero wait states
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
            if (paddr == HOST_CTRL_OFS)
                prdata_q[1:0] <= ctrl_q;
            else if (paddr == HOST_STATUS_OFS)
            begin
                prdata_q[ST_TX_BUSY_BIT] <= tx_on_q;
                prdata_q[ST_RX_VALID_BIT] <= rx_vld_q;
                prdata_q[ST_RX_FERR_BIT] <= rx_ferr_q;
            end
            else if (paddr == HOST_RXDATA_OFS)
                prdata_q[7:0] <= rx_data_q;
            else if (paddr != HOST_TXDATA_OFS)
                pslverr_q <= 1'b1;
            if (pwrite && paddr == HOST_TXDATA_OFS && tx_on_q)
                pslverr_q <= 1'b1;
        end
    end

    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign link.sclk = sclk_q;
    assign link.boot_rst_n = dev_rst_n_q;
    assign link.rxd = txd_q;
endmodule

// file: sbpl_link_monitor.sv
// Protocol checker for the serial boot link wires
`timescale 1ns/10ps
module sbpl_link_monitor (
    // Link signals
    input wire logic sclk,
    input wire logic boot_rst_n,
    input wire logic rxd,
    input wire logic txd
);
    logic [7:0] tc_q, rc_q, txn_q, rxn_q;
    default clocking @(posedge sclk); endclocking
    default disable iff (!boot_rst_n);
    // Frame position in sclk ticks, 0 while idle
    always_ff @(posedge sclk or negedge boot_rst_n)
    begin
        if (!boot_rst_n)
        begin
            tc_q <= 8'h00;
            rc_q <= 8'h00;
            txn_q <= 8'h00;
            rxn_q <= 8'h00;
        end
        else
        begin
            tc_q <= (tc_q == 8'h9F) ? 8'h00 : (tc_q != 8'h00 || !txd) ? tc_q + 8'h01 : 8'h00;
            rc_q <= (rc_q == 8'h9F) ? 8'h00 : (rc_q != 8'h00 || !rxd) ? rc_q + 8'h01 : 8'h00;
            txn_q <= txn_q + {7'h00, tc_q == 8'h00 && !txd};
            rxn_q <= rxn_q + {7'h00, rc_q == 8'h90};
        end
    end
    a_tx_start_low: assert property (tc_q > 8'h00 && tc_q < 8'h10 |-> !txd)
        else $error("echo start bit not low");
    a_tx_stop_high: assert property (tc_q >= 8'h90 |-> txd)
        else $error("echo stop bit not high");
    a_tx_bit_edges: assert property ($changed(txd) && tc_q != 8'h00 |-> tc_q[3:0] == 4'h0)
        else $error("echo bit not sixteen ticks long");
    a_rx_start_mid: assert property (rc_q == 8'h08 |-> !rxd)
        else $error("host start bit not low");
    a_rx_stop_mid: assert property (rc_q == 8'h98 |-> rxd)
        else $error("host stop bit not high");
    a_idle_release: assert property ($rose(boot_rst_n) |-> txd && rxd)
        else $error("data lines not idle at release");
    a_echo_follows: assert property (tc_q == 8'h00 && !txd |-> rxn_q != txn_q)
        else $error("echo without received byte");
    a_echo_within: assert property (rc_q == 8'h90 |-> ##[1:200] (tc_q == 8'h00 && !txd))
        else $error("no echo after received byte");
    cover property (tc_q == 8'h9F);
    cover property (rc_q == 8'h9F);
    cover property ($rose(boot_rst_n));
endmodule

// file: serial_boot_program_loader_bench.sv
// Bench joining host and device ends over the serial boot link
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module serial_boot_program_loader_bench;
    import sbpl_pkg::*;
    logic mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd, seed = 32'h0000_b24c;
    logic [3:0] pins = 4'h0, lat;
    logic pmem_we, boot_active, exec_go;
    logic [23:0] pmem_addr, pmem_data, fetch_addr, spc, scc, base;
    logic [23:0] words [8];
    int widx, execs, mismatches, comparisons, cycles;
    sbpl_link_if link ();
    sbpl_host #(.SCLK_HALF(1)) i_sbpl_host (.mclk(mclk), .rstn(rstn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link));
    sbpl_device i_sbpl_device (.link(link), .boot_select_pin_a(pins[0]),
        .boot_select_pin_b(pins[1]), .boot_select_pin_c(pins[2]), .boot_select_pin_d(pins[3]),
        .latched_select_bit_a(lat[0]), .latched_select_bit_b(lat[1]),
        .latched_select_bit_c(lat[2]), .latched_select_bit_d(lat[3]),
        .serial_port_control(spc), .serial_port_clock_control(scc), .pmem_we(pmem_we),
        .pmem_addr(pmem_addr), .pmem_data(pmem_data), .boot_active(boot_active),
        .exec_go(exec_go), .fetch_addr(fetch_addr));
    sbpl_link_monitor i_sbpl_link_monitor (.sclk(link.sclk), .boot_rst_n(link.boot_rst_n),
        .rxd(link.rxd), .txd(link.txd));
    always #10 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 50000)
        begin
            mismatches++;
            print_verdict();
        end
    end
    // Each program write must land at the next address with the next word
    always @(posedge link.sclk)
    begin
        if (pmem_we === 1'b1)
        begin
            `CHK("pmem_addr", base + 24'(widx), pmem_addr)
            `CHK("pmem_data", words[widx], pmem_data)
            widx++;
        end
        if (exec_go === 1'b1)
            execs++;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Entered right after a rising edge; returns one idle cycle after the access
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task send(input logic [7:0] b);
        apb(1'b1, HOST_TXDATA_OFS, {24'h00_0000, b});
        apb(1'b1, HOST_TXDATA_OFS, {24'h00_0000, ~b});
        `CHK("busy_err", 1'b1, er)
        rd = 32'h0000_0000;
        while (rd[ST_RX_VALID_BIT] !== 1'b1)
            apb(1'b0, HOST_STATUS_OFS, 32'h0000_0000);
        `CHK("frame_err", 1'b0, rd[ST_RX_FERR_BIT])
        apb(1'b0, HOST_RXDATA_OFS, 32'h0000_0000);
        `CHK("echo", b, rd[7:0])
    endtask
    task word(input logic [23:0] w);
        send(w[7:0]);
        send(w[15:8]);
        send(w[23:16]);
    endtask
    task boot(input logic [3:0] p);
        apb(1'b1, HOST_CTRL_OFS, 32'h0000_0003);
        pins <= p;
        repeat (8) @(posedge mclk);
        `CHK("port_ctrl", PORT_CONTROL_BOOT, spc)
        `CHK("clock_ctrl", CLOCK_CONTROL_BOOT, scc)
        apb(1'b1, HOST_CTRL_OFS, 32'h0000_0002);
        // Straps need a few sclk ticks to settle before the latch
        repeat (40) @(posedge mclk);
        `CHK("latched", p, lat)
        `CHK("boot_active", p == SERIAL_BOOT_MODE, boot_active)
        widx = 0;
        execs = 0;
    endtask
    task load(input int n);
        seed = lfsr(seed);
        base = {1'b0, seed[22:0]};
        word(24'(n));
        word(base);
        for (int i = 0; i < n; i++)
        begin
            seed = lfsr(seed);
            words[i] = seed[23:0];
            word(words[i]);
        end
        repeat (8) @(posedge mclk);
        `CHK("word_count", n, widx)
        `CHK("exec_count", 1, execs)
        `CHK("fetch_addr", base, fetch_addr)
        $display("load of %0d words done", n);
    endtask
    initial
    begin
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        apb(1'b0, HOST_CTRL_OFS, 32'h0000_0000);
        `CHK("ctrl_reset", 32'(HOST_CTRL_RESET), rd)
        apb(1'b0, 12'h0F0, 32'h0000_0000);
        `CHK("unmapped_err", 1'b1, er)
        $display("register test done");
        boot(4'hA);
        $display("other mode test done");
        boot(SERIAL_BOOT_MODE);
        `CHK("entry", BOOT_ENTRY, fetch_addr)
        load(0);
        boot(SERIAL_BOOT_MODE);
        load(5);
        boot(SERIAL_BOOT_MODE);
        word(LOADER_WORDS);
        word(base);
        repeat (8) @(posedge mclk);
        `CHK("loader_wait", 1'b1, boot_active)
        `CHK("loader_exec", 0, execs)
        $display("loader count test done");
        print_verdict();
    end
endmodule
